/* hdl/pif_cfg.svh */
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH
// Register byte offsets
`define PIF_OFS_HDR     8'h00
`define PIF_OFS_VAL     8'h04
`define PIF_OFS_SUM     8'h08
`define PIF_OFS_REPLY   8'h0c
`define PIF_OFS_ERR     8'h10
`define PIF_OFS_INTCTL  8'h14
`define PIF_OFS_ISTAT   8'h18
`define PIF_OFS_IMASK   8'h1c
// Opcodes and type codes
`define PIF_OP_CLEAR    8'h24
`define PIF_OP_ENABLE   8'h19
`define PIF_OP_DISABLE  8'h1a
`define PIF_OP_VECTOR   8'h25
`define PIF_OP_RETURN   8'h26
`define PIF_TYPE_ALL    8'h00
`define PIF_TYPE_LAST   8'h05
`define PIF_TYPE_GLOBAL 8'hff
// Reply status codes
`define PIF_ST_OK       8'h64
`define PIF_ST_BADSUM   8'h01
`define PIF_ST_BADCMD   8'h02
// Interrupt status bit positions
`define PIF_IRQ_DONE    0
`define PIF_IRQ_BADSUM  1
`define PIF_IRQ_ENTER   2
// Reset values
`define PIF_RST_ENMASK  8'h00
`define PIF_RST_IMASK   3'h0
`define PIF_RST_ERR     5'h00
`endif

/* hdl/pif_pkg.sv */
package pif_pkg;
  localparam int NumInt = 8;

  typedef struct packed {
    logic [7:0]  target;
    logic [7:0]  instr;
    logic [7:0]  ctype;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  sum;
  } pif_frame_t;

  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] xreg;
    logic [7:0]  flags;
    logic [31:0] pc;
  } pif_engine_t;

  typedef struct packed {
    logic        shutdownFlag;
    logic        positionErrorFlag;
    logic        deviationFlag;
    logic        externalAlarmFlag;
    logic        timeoutFlag;
  } pif_errflags_t;
endpackage : pif_pkg

/* hdl/pif_top.sv */
`include "pif_cfg.svh"

// Operation
// - Opcode 36 clears error flags by type
// - Type 0 all; 1-5 one flag each
// - Bank byte and value ignored there
// - Opcode 25 enables one interrupt
// - Enable with 255 turns global on
// - Opcode 26 disables one interrupt
// - Disable with 255 turns global off
// - Opcode 37 stores handler entry address
// - Redefining a vector overwrites it
// - Opcode 38 ends handler, resumes program
// - Return restores acc, X, flags, PC
// - Frame is nine bytes, fixed order
module pif_top (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  input  wire logic                progCmdValid,
  input  wire pif_pkg::pif_frame_t progCmd,
  output logic                     progCmdAck,
  input  wire pif_pkg::pif_engine_t engState,
  input  wire logic [7:0]          intSrc,
  input  wire logic [4:0]          errSet,
  output pif_pkg::pif_errflags_t   errFlags,
  output logic                     engLoad,
  output pif_pkg::pif_engine_t     engLoadState,
  output logic                     inHandler,
  output logic                     irq
);
  import pif_pkg::*;

  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [31:0] hdr_q;
  logic [31:0] val_q;
  logic [7:0]  replyStatus_q;
  logic [7:0]  replyOp_q;
  logic [4:0]  err_q;
  logic [7:0]  enMask_q;
  logic        globalEn_q;
  logic [7:0]  pending_q;
  logic [31:0] vector_q [NumInt];
  pif_engine_t saved_q;
  logic        inHandler_q;
  logic        engLoad_q;
  pif_engine_t engLoadState_q;
  logic        progAck_q;
  logic [2:0]  istat_q;
  logic [2:0]  imask_q;
  logic        irq_q;

  logic        access;
  logic        doWr;
  logic        mapped;
  logic        hostGo;
  logic        progGo;
  logic        exec;
  pif_frame_t  frame;
  logic        sumOk;
  logic        knownOp;
  logic        isClear;
  logic        isEnable;
  logic        isDisable;
  logic        isVector;
  logic        isReturn;
  logic        typeInt;
  logic [2:0]  intIdx;
  logic [7:0]  takeVec;
  logic        take;
  logic [2:0]  takeIdx;
  logic [4:0]  errClr;

  function automatic logic [7:0] frame_sum(input pif_frame_t f);
    logic [7:0] s;
    s = f.target + f.instr + f.ctype + f.bank;
    s = s + f.value[31:24] + f.value[23:16] + f.value[15:8] + f.value[7:0];
    return s;
  endfunction : frame_sum

  // APB slave: one wait state, answer in second access cycle
  assign access = psel && penable && !pready_q;
  assign doWr   = psel && penable && pready_q && pwrite;
  always_comb begin
    unique case (paddr)
      `PIF_OFS_HDR, `PIF_OFS_VAL, `PIF_OFS_SUM, `PIF_OFS_REPLY,
      `PIF_OFS_ERR, `PIF_OFS_INTCTL, `PIF_OFS_ISTAT, `PIF_OFS_IMASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !mapped;
      prdata_q  <= 32'h0;
      if (access && !pwrite) begin
        unique case (paddr)
          `PIF_OFS_HDR:    prdata_q <= hdr_q;
          `PIF_OFS_VAL:    prdata_q <= val_q;
          `PIF_OFS_REPLY:  prdata_q <= {16'h0, replyOp_q, replyStatus_q};
          `PIF_OFS_ERR:    prdata_q <= {27'h0, err_q};
          `PIF_OFS_INTCTL: prdata_q <= {15'h0, inHandler_q, 7'h0, globalEn_q, enMask_q};
          `PIF_OFS_ISTAT:  prdata_q <= {29'h0, istat_q};
          `PIF_OFS_IMASK:  prdata_q <= {29'h0, imask_q};
          default:         prdata_q <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hdr_q <= 32'h0;
      val_q <= 32'h0;
    end else if (doWr && paddr == `PIF_OFS_HDR) begin
      hdr_q <= pwdata;
    end else if (doWr && paddr == `PIF_OFS_VAL) begin
      val_q <= pwdata;
    end
  end

  // Host frame completes on the checksum write; it beats a program command
  assign hostGo = doWr && paddr == `PIF_OFS_SUM;
  assign progGo = progCmdValid && !progAck_q && !hostGo;
  assign exec   = hostGo || progGo;
  always_comb begin
    frame = progCmd;
    if (hostGo) begin
      frame = {hdr_q, val_q, pwdata[7:0]};
    end
  end

  assign sumOk     = frame_sum(frame) == frame.sum;
  assign isClear   = frame.instr == `PIF_OP_CLEAR;
  assign isEnable  = frame.instr == `PIF_OP_ENABLE;
  assign isDisable = frame.instr == `PIF_OP_DISABLE;
  assign isVector  = frame.instr == `PIF_OP_VECTOR;
  assign isReturn  = frame.instr == `PIF_OP_RETURN;
  assign knownOp   = isClear || isEnable || isDisable || isVector || isReturn;
  assign typeInt   = frame.ctype < 8'(NumInt);
  assign intIdx    = frame.ctype[2:0];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      progAck_q <= 1'b0;
    end else begin
      progAck_q <= progGo;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      replyStatus_q <= 8'h0;
      replyOp_q     <= 8'h0;
    end else if (hostGo) begin
      replyOp_q <= frame.instr;
      if (!sumOk) begin
        replyStatus_q <= `PIF_ST_BADSUM;
      end else if (knownOp) begin
        replyStatus_q <= `PIF_ST_OK;
      end else begin
        replyStatus_q <= `PIF_ST_BADCMD;
      end
    end
  end

  // Bank byte and value never reach the clear decode
  always_comb begin
    errClr = 5'h0;
    if (exec && sumOk && isClear) begin
      if (frame.ctype == `PIF_TYPE_ALL) begin
        errClr = 5'h1f;
      end else if (frame.ctype <= `PIF_TYPE_LAST) begin
        errClr = 5'h1 << (frame.ctype[2:0] - 3'h1);
      end
    end
  end

  // A new error in the clearing cycle survives
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      err_q <= `PIF_RST_ERR;
    end else begin
      err_q <= (err_q & ~errClr) | errSet;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      enMask_q   <= `PIF_RST_ENMASK;
      globalEn_q <= 1'b0;
    end else if (exec && sumOk && isEnable) begin
      if (frame.ctype == `PIF_TYPE_GLOBAL) begin
        globalEn_q <= 1'b1;
      end else if (typeInt) begin
        enMask_q[intIdx] <= 1'b1;
      end
    end else if (exec && sumOk && isDisable) begin
      if (frame.ctype == `PIF_TYPE_GLOBAL) begin
        globalEn_q <= 1'b0;
      end else if (typeInt) begin
        enMask_q[intIdx] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NumInt; i++) begin
        vector_q[i] <= 32'h0;
      end
    end else if (exec && sumOk && isVector && typeInt) begin
      vector_q[intIdx] <= frame.value;
    end
  end

  // Interrupt entry waits for a quiet cycle; lowest number wins
  assign takeVec = pending_q & enMask_q;
  assign take    = globalEn_q && !inHandler_q && |takeVec && !exec;
  always_comb begin
    takeIdx = 3'h0;
    for (int i = NumInt - 1; i >= 0; i--) begin
      if (takeVec[i]) begin
        takeIdx = 3'(i);
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_q <= 8'h0;
    end else begin
      pending_q <= (pending_q & ~(take ? 8'h1 << takeIdx : 8'h0)) | intSrc;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      saved_q        <= '0;
      inHandler_q    <= 1'b0;
      engLoad_q      <= 1'b0;
      engLoadState_q <= '0;
    end else begin
      engLoad_q <= 1'b0;
      if (take) begin
        saved_q           <= engState;
        inHandler_q       <= 1'b1;
        engLoad_q         <= 1'b1;
        engLoadState_q    <= engState;
        engLoadState_q.pc <= vector_q[takeIdx];
      end else if (exec && sumOk && isReturn && inHandler_q) begin
        inHandler_q    <= 1'b0;
        engLoad_q      <= 1'b1;
        engLoadState_q <= saved_q;
      end
    end
  end

  // Interrupt status: set beats write-one-clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_q <= 3'h0;
      imask_q <= `PIF_RST_IMASK;
      irq_q   <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~((doWr && paddr == `PIF_OFS_ISTAT) ? pwdata[2:0] : 3'h0))
                 | {take, hostGo && !sumOk, hostGo};
      if (doWr && paddr == `PIF_OFS_IMASK) begin
        imask_q <= pwdata[2:0];
      end
      irq_q <= |(istat_q & imask_q);
    end
  end

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign progCmdAck   = progAck_q;
  assign errFlags     = err_q;
  assign engLoad      = engLoad_q;
  assign engLoadState = engLoadState_q;
  assign inHandler    = inHandler_q;
  assign irq          = irq_q;

  a_clear_all: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isClear && frame.ctype == 8'h00 && errSet == 5'h0 |=> err_q == 5'h0)
    else $error("clear-all left a flag set");
  a_clear_one: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isClear && frame.ctype == 8'h01 && !errSet[0]
      |=> !err_q[0] && err_q[4:1] == $past(err_q[4:1] | errSet[4:1]))
    else $error("single clear touched the wrong flag");
  a_enable_global: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isEnable && frame.ctype == 8'hff |=> globalEn_q && $stable(enMask_q))
    else $error("global enable failed");
  a_disable_global: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isDisable && frame.ctype == 8'hff |=> !globalEn_q)
    else $error("global disable failed");
  a_enable_one: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isEnable && frame.ctype == 8'h03 |=> enMask_q[3])
    else $error("single enable failed");
  a_disable_one: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isDisable && frame.ctype == 8'h03 |=> !enMask_q[3])
    else $error("single disable failed");
  a_vector_store: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isVector && frame.ctype == 8'h03
      |=> vector_q[3] == $past(frame.value))
    else $error("vector not stored");
  a_entry_jump: assert property (@(posedge mclk) disable iff (sys_rst)
    take |=> engLoad_q && inHandler_q && engLoadState_q.acc == $past(engState.acc))
    else $error("interrupt entry did not jump");
  a_return_restore: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && sumOk && isReturn && inHandler_q && !take
      |=> engLoad_q && !inHandler_q && engLoadState_q == $past(saved_q))
    else $error("return did not restore state");
  a_reply_ok: assert property (@(posedge mclk) disable iff (sys_rst)
    hostGo && sumOk && knownOp |=> replyStatus_q == 8'h64)
    else $error("reply not OK");
  a_bad_sum: assert property (@(posedge mclk) disable iff (sys_rst)
    exec && !sumOk
      |=> $stable(enMask_q) && $stable(globalEn_q) && (istat_q[1] || !$past(hostGo)))
    else $error("bad checksum acted");
endmodule : pif_top

/* dv/pif_prog_model.sv */
// Stands in for the stored program and the engine beside it
module pif_prog_model (
  input  wire logic                 mclk,
  input  wire logic                 progCmdAck,
  output logic                      progCmdValid,
  output pif_pkg::pif_frame_t       progCmd,
  output pif_pkg::pif_engine_t      engState,
  output logic [7:0]                intSrc,
  output logic [4:0]                errSet
);
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;

  initial begin
    progCmdValid = 1'b0;
    progCmd      = '0;
    engState     = '0;
    intSrc       = 8'h00;
    errSet       = 5'h00;
  end

  // Vector and return frames come only from here, never from the host
  task automatic send(input logic [7:0] instr, input logic [7:0] ctype,
                      input logic [31:0] value);
    pif_frame_t f;
    f = '{8'h01, instr, ctype, 8'h00, value, 8'h00};
    f.sum = f.target + f.instr + f.ctype + f.bank + value[31:24] + value[23:16]
          + value[15:8] + value[7:0];
    @(posedge mclk);
    progCmdValid <= 1'b1;
    progCmd      <= f;
    do @(posedge mclk); while (progCmdAck !== 1'b1);
    progCmdValid <= 1'b0;
    // Released bus must not look like the last frame
    progCmd      <= ~f;
  endtask : send

  task automatic pulse(input logic [7:0] irqs, input logic [4:0] errs);
    @(posedge mclk);
    intSrc <= irqs;
    errSet <= errs;
    @(posedge mclk);
    intSrc <= 8'h00;
    errSet <= 5'h00;
  endtask : pulse

  task automatic setEng(input pif_engine_t s);
    @(posedge mclk);
    engState <= s;
  endtask : setEng
endmodule : pif_prog_model

/* dv/pif_top_tb.sv */
`include "pif_cfg.svh"

module pif_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pif_pkg::*;

  logic          mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]    paddr, intSrc;
  logic [31:0]   pwdata, prdata, rd, e;
  logic          progCmdValid, progCmdAck, engLoad, inHandler, irq, hand;
  logic [4:0]    errSet;
  pif_frame_t    progCmd;
  pif_engine_t   engState, engLoadState, ld;
  pif_errflags_t errFlags;
  int            failures, comparisons, loads;
  logic [7:0]    ops [4] = '{`PIF_OP_ENABLE, `PIF_OP_ENABLE, `PIF_OP_DISABLE, `PIF_OP_DISABLE};
  logic [7:0]    typs [4] = '{8'h03, 8'hff, 8'h03, 8'hff};
  logic [31:0]   exps [4] = '{32'h8, 32'h108, 32'h100, 32'h0};

  pif_top dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .progCmdValid(progCmdValid), .progCmd(progCmd),
    .progCmdAck(progCmdAck), .engState(engState), .intSrc(intSrc), .errSet(errSet),
    .errFlags(errFlags), .engLoad(engLoad), .engLoadState(engLoadState),
    .inHandler(inHandler), .irq(irq));
  pif_prog_model prog (.mclk(mclk), .progCmdAck(progCmdAck), .progCmdValid(progCmdValid),
    .progCmd(progCmd), .engState(engState), .intSrc(intSrc), .errSet(errSet));

  always #2 mclk = ~mclk;

  // Load pulses last one cycle, so catch them as they pass
  always @(negedge mclk) begin
    if (engLoad === 1'b1) begin
      loads++;
      ld   = engLoadState;
      hand = inHandler;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Read just after the edge: these are the values that edge sampled
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [7:0] instr, input logic [7:0] ctype, input logic [7:0] bank,
                     input logic [31:0] value, input logic [7:0] skew, input logic [7:0] st);
    logic [7:0] s;
    s = 8'h01 + instr + ctype + bank + value[31:24] + value[23:16] + value[15:8]
      + value[7:0] + skew;
    apb(1'b1, `PIF_OFS_HDR, {8'h01, instr, ctype, bank});
    apb(1'b1, `PIF_OFS_VAL, value);
    apb(1'b1, `PIF_OFS_SUM, {24'h0, s});
    apb(1'b0, `PIF_OFS_REPLY, 32'h0);
    chk("reply", {16'h0, instr, st}, rd);
  endtask : cmd

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  initial begin
    #40000;
    failures++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end

  initial begin
    mclk = 1'b0; sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b0, `PIF_OFS_ERR, 32'h0);
    chk("err reset", 32'h0, rd);
    apb(1'b0, `PIF_OFS_INTCTL, 32'h0);
    chk("intctl reset", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("reset test done");
    for (int k = 0; k <= 6; k++) begin
      prog.pulse(8'h00, 5'h1f);
      cmd(`PIF_OP_CLEAR, 8'(k), 8'h5a, 32'hdeadbeef, 8'h00, `PIF_ST_OK);
      e = (k == 0) ? 32'h0 : (k > 5) ? 32'h1f : (32'h1f & ~(32'h1 << (k - 1)));
      apb(1'b0, `PIF_OFS_ERR, 32'h0);
      chk("err flags", e, rd);
      chk("err port", e, {27'h0, errFlags});
    end
    apb(1'b1, `PIF_OFS_IMASK, 32'h2);
    cmd(`PIF_OP_CLEAR, 8'h00, 8'h00, 32'h0, 8'h01, `PIF_ST_BADSUM);
    apb(1'b0, `PIF_OFS_ERR, 32'h0);
    chk("err kept", 32'h1f, rd);
    chk("irq raised", 32'h1, {31'h0, irq});
    cmd(8'h27, 8'h00, 8'h00, 32'h0, 8'h00, `PIF_ST_BADCMD);
    apb(1'b1, `PIF_OFS_ISTAT, 32'h7);
    // Status clears at the write edge, irq follows one cycle later
    repeat (2) @(negedge mclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("error flag test done");
    for (int k = 0; k < 4; k++) begin
      cmd(ops[k], typs[k], 8'h00, 32'h0, 8'h00, `PIF_ST_OK);
      apb(1'b0, `PIF_OFS_INTCTL, 32'h0);
      chk("intctl", exps[k], rd);
    end
    $display("enable test done");
    prog.send(`PIF_OP_VECTOR, 8'h03, 32'h32);
    prog.send(`PIF_OP_VECTOR, 8'h03, 32'h77);
    prog.send(`PIF_OP_ENABLE, 8'h03, 32'h0);
    prog.send(`PIF_OP_ENABLE, `PIF_TYPE_GLOBAL, 32'h0);
    prog.setEng('{32'h11111111, 32'h22222222, 8'h33, 32'h44});
    prog.pulse(8'h08, 5'h00);
    for (int i = 0; i < 20 && loads < 1; i++) @(negedge mclk);
    chk("entry pc", 32'h77, ld.pc);
    chk("entry acc", 32'h11111111, ld.acc);
    chk("entry handler", 32'h1, {31'h0, hand});
    prog.setEng('{32'h55, 32'h66, 8'h77, 32'h80});
    prog.send(`PIF_OP_RETURN, 8'hff, 32'h0);
    for (int i = 0; i < 20 && loads < 2; i++) @(negedge mclk);
    chk("ret acc", 32'h11111111, ld.acc);
    chk("ret x", 32'h22222222, ld.xreg);
    chk("ret flags", 32'h33, {24'h0, ld.flags});
    chk("ret pc", 32'h44, ld.pc);
    chk("ret handler", 32'h0, {31'h0, hand});
    apb(1'b0, `PIF_OFS_ISTAT, 32'h0);
    chk("istat", 32'h5, rd);
    apb(1'b0, `PIF_OFS_IMASK, 32'h0);
    chk("imask", 32'h2, rd);
    $display("handler test done");
    results();
  end
endmodule : pif_top_tb
